// file: rtl/amm_dec_if.sv
// Decoded instruction fields passed from decoder to executor
`timescale 1ns/10ps
interface amm_dec_if;
    import amm_pkg::*;
    logic match;
    logic undef;
    amo_op_e op;
    logic [1:0] size;
    logic acquire;
    logic release_o;
    logic tag_check;
    logic use_sp;
    logic discard;
    logic dst_is64;
    logic [4:0] src_idx;
    logic [4:0] base_idx;
    logic [4:0] dst_idx;

    modport dec (output match, undef, op, size, acquire, release_o, tag_check, use_sp,
        discard, dst_is64, src_idx, base_idx, dst_idx);
    modport exec (input match, undef, op, size, acquire, release_o, tag_check, use_sp,
        discard, dst_is64, src_idx, base_idx, dst_idx);
endinterface : amm_dec_if

// file: rtl/amm_decode.sv
// Field extraction and attribute decode for the signed min/max atomics
`timescale 1ns/10ps
module amm_decode
    import amm_pkg::*;
(
    input wire logic [31:0] instr,
    input wire logic large_system_ext_feature,
    amm_dec_if.dec d
);
    logic [2:0] opc;
    logic [4:0] dst;
    logic [4:0] base;

    assign opc = instr[opc_hi:opc_lo];
    assign dst = instr[dst_hi:dst_lo];
    assign base = instr[base_hi:base_lo];

    always_comb begin
        d.match = (instr[fixed_hi:fixed_lo] == fixed_val) && instr[one_pos]
            && !instr[o3_pos] && (instr[z_hi:z_lo] == 2'h0)
            && ((opc == opc_smax) || (opc == opc_smin));
        // Whole class is absent without the feature
        d.undef = !large_system_ext_feature || !d.match;
        d.op = (opc == opc_smin) ? op_smin : op_smax;
        d.size = instr[size_hi:size_lo];
        d.acquire = instr[acq_pos] && (dst != zero_idx);
        d.release_o = instr[rel_pos];
        d.tag_check = (base != zero_idx);
        d.use_sp = (base == zero_idx);
        d.discard = (dst == zero_idx);
        d.dst_is64 = (instr[size_hi:size_lo] == size_dword);
        d.src_idx = instr[src_hi:src_lo];
        d.base_idx = base;
        d.dst_idx = dst;
    end
endmodule : amm_decode

// file: rtl/amm_minmax.sv
// Signed maximum or minimum at byte, halfword, word or doubleword width
`timescale 1ns/10ps
module amm_minmax
    import amm_pkg::*;
(
    input wire logic [1:0] size,
    input wire amo_op_e op,
    input wire logic [63:0] mem_val,
    input wire logic [63:0] reg_val,
    output logic [63:0] result
);
    logic signed [63:0] m_sx;
    logic signed [63:0] r_sx;
    logic r_greater;

    always_comb begin
        m_sx = size_sext(size, mem_val);
        r_sx = size_sext(size, reg_val);
        r_greater = (r_sx > m_sx);
        // Max keeps the larger, min the smaller
        if (op == op_smax) begin
            result = size_mask(size, r_greater ? reg_val : mem_val);
        end else begin
            result = size_mask(size, r_greater ? mem_val : reg_val);
        end
    end
endmodule : amm_minmax

// file: rtl/amm_pkg.sv
// Shared constants and types for the signed min/max atomic executor
package amm_pkg;
    localparam int instr_w = 32;
    localparam int data_w = 64;
    localparam int idx_w = 5;
    localparam logic [4:0] zero_idx = 5'h1f;
    // Instruction field positions
    localparam int size_hi = 31;
    localparam int size_lo = 30;
    localparam int fixed_hi = 29;
    localparam int fixed_lo = 24;
    localparam int acq_pos = 23;
    localparam int rel_pos = 22;
    localparam int one_pos = 21;
    localparam int src_hi = 20;
    localparam int src_lo = 16;
    localparam int o3_pos = 15;
    localparam int opc_hi = 14;
    localparam int opc_lo = 12;
    localparam int z_hi = 11;
    localparam int z_lo = 10;
    localparam int base_hi = 9;
    localparam int base_lo = 5;
    localparam int dst_hi = 4;
    localparam int dst_lo = 0;
    // Fixed encoding values
    localparam logic [5:0] fixed_val = 6'h38;
    localparam logic [2:0] opc_smax = 3'h4;
    localparam logic [2:0] opc_smin = 3'h5;
    localparam logic [1:0] size_byte = 2'h0;
    localparam logic [1:0] size_half = 2'h1;
    localparam logic [1:0] size_word = 2'h2;
    localparam logic [1:0] size_dword = 2'h3;
    localparam logic [3:0] sp_align_mask = 4'hf;
    localparam logic [63:0] cmp_unused = 64'h0;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_regrd = 3'b001,
        st_issue = 3'b010,
        st_wait_old = 3'b011,
        st_write = 3'b100,
        st_wb = 3'b101
    } exec_state_e;

    typedef enum logic {
        op_smax = 1'b0,
        op_smin = 1'b1
    } amo_op_e;

    // Keeps the low (8 << size) bits
    function automatic logic [63:0] size_mask(input logic [1:0] sz, input logic [63:0] v);
        logic [63:0] r;
        r = v;
        case (sz)
            size_byte: r = {56'h0, v[7:0]};
            size_half: r = {48'h0, v[15:0]};
            size_word: r = {32'h0, v[31:0]};
            default: r = v;
        endcase
        return r;
    endfunction : size_mask

    // Sign extends the low (8 << size) bits
    function automatic logic [63:0] size_sext(input logic [1:0] sz, input logic [63:0] v);
        logic [63:0] r;
        r = v;
        case (sz)
            size_byte: r = {{56{v[7]}}, v[7:0]};
            size_half: r = {{48{v[15]}}, v[15:0]};
            size_word: r = {{32{v[31]}}, v[31:0]};
            default: r = v;
        endcase
        return r;
    endfunction : size_sext
endpackage : amm_pkg

// file: rtl/atomic_signed_minmax_exec.sv
// Executor for signed max/min atomics: decode, operand fetch, RMW, writeback
`timescale 1ns/10ps
module atomic_signed_minmax_exec
    import amm_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic large_system_ext_feature,
    input wire logic sp_align_check_en,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [31:0] instr,
    output logic [4:0] rf_src_idx,
    input wire logic [63:0] rf_src_data,
    output logic [4:0] rf_base_idx,
    input wire logic [63:0] rf_base_data,
    input wire logic [63:0] sp_value,
    output logic undef_exc,
    output logic sp_align_fault,
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic [63:0] mem_addr,
    output logic mem_op_min,
    output logic [1:0] mem_size,
    output logic mem_acquire,
    output logic mem_release,
    output logic mem_tag_check,
    output logic [63:0] mem_operand,
    output logic [63:0] mem_cmp_data,
    input wire logic mem_old_valid,
    input wire logic [63:0] mem_old_data,
    output logic mem_new_valid,
    input wire logic mem_new_ready,
    output logic [63:0] mem_new_data,
    output logic wb_valid,
    output logic [4:0] wb_idx,
    output logic wb_is64,
    output logic [63:0] wb_data
);
    amm_dec_if dif ();
    amm_dec_if lat ();

    exec_state_e state_reg;
    exec_state_e state_next;
    logic [31:0] instr_reg;
    logic [63:0] addr_reg;
    logic [63:0] operand_reg;
    logic [63:0] old_reg;
    logic [63:0] new_reg;
    logic undef_reg;
    logic fault_reg;
    logic wb_reg;
    logic [63:0] merged;
    logic sp_misaligned;

    amm_decode u_dec_in (
        .instr(instr),
        .large_system_ext_feature(large_system_ext_feature),
        .d(dif.dec)
    );

    // Latched copy drives the rest of the operation
    amm_decode u_dec_lat (
        .instr(instr_reg),
        .large_system_ext_feature(1'b1),
        .d(lat.dec)
    );

    amm_minmax u_mm (
        .size(lat.size),
        .op(lat.op),
        .mem_val(mem_old_data),
        .reg_val(operand_reg),
        .result(merged)
    );

    assign instr_ready = (state_reg == st_idle);
    assign rf_src_idx = lat.src_idx;
    assign rf_base_idx = lat.base_idx;
    assign sp_misaligned = lat.use_sp && sp_align_check_en
        && ((sp_value[3:0] & sp_align_mask) != 4'h0);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            st_idle: begin
                if (instr_valid && !dif.undef) begin
                    state_next = st_regrd;
                end
            end
            st_regrd: begin
                state_next = sp_misaligned ? st_idle : st_issue;
            end
            st_issue: begin
                if (mem_req_ready) begin
                    state_next = st_wait_old;
                end
            end
            st_wait_old: begin
                if (mem_old_valid) begin
                    state_next = st_write;
                end
            end
            st_write: begin
                if (mem_new_ready) begin
                    state_next = st_wb;
                end
            end
            st_wb: begin
                state_next = st_idle;
            end
            default: begin
                state_next = st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= st_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            instr_reg <= 32'h0;
        end else if (state_reg == st_idle && instr_valid && !dif.undef) begin
            instr_reg <= instr;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            undef_reg <= 1'b0;
        end else begin
            undef_reg <= (state_reg == st_idle) && instr_valid && dif.undef;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= (state_reg == st_regrd) && sp_misaligned;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            addr_reg <= 64'h0;
            operand_reg <= 64'h0;
        end else if (state_reg == st_regrd) begin
            addr_reg <= lat.use_sp ? sp_value : rf_base_data;
            operand_reg <= size_mask(lat.size, rf_src_data);
        end
    end

    // Old value kept apart from the merged one so the register gets the original
    always_ff @(posedge mclk) begin
        if (reset) begin
            old_reg <= 64'h0;
        end else if (state_reg == st_wait_old && mem_old_valid) begin
            old_reg <= size_mask(lat.size, mem_old_data);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            new_reg <= 64'h0;
        end else if (state_reg == st_wait_old && mem_old_valid) begin
            // Merged straight from the bus so it is ready when the write starts
            new_reg <= merged;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_reg <= 1'b0;
        end else begin
            wb_reg <= (state_reg == st_write) && mem_new_ready && !lat.discard;
        end
    end

    // Request attributes held steady while waiting on the memory
    always_comb begin
        mem_req_valid = (state_reg == st_issue);
        mem_addr = addr_reg;
        mem_op_min = (lat.op == op_smin);
        mem_size = lat.size;
        mem_acquire = lat.acquire;
        mem_release = lat.release_o;
        mem_tag_check = lat.tag_check;
        mem_operand = operand_reg;
        mem_cmp_data = cmp_unused;
        mem_new_valid = (state_reg == st_write);
        mem_new_data = new_reg;
    end

    assign undef_exc = undef_reg;
    assign sp_align_fault = fault_reg;
    assign wb_valid = wb_reg;
    assign wb_idx = lat.dst_idx;
    assign wb_is64 = lat.dst_is64;
    // Upper half already zero for narrow sizes
    assign wb_data = old_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_acquire;
        mem_req_valid |-> mem_acquire == (instr_reg[acq_pos] && instr_reg[4:0] != zero_idx);
    endproperty
    a_acquire: assert property (p_acquire) else $error("acquire attribute wrong");

    property p_release;
        mem_req_valid |-> mem_release == instr_reg[rel_pos];
    endproperty
    a_release: assert property (p_release) else $error("release attribute wrong");

    property p_tag;
        mem_req_valid |-> mem_tag_check == (instr_reg[9:5] != zero_idx);
    endproperty
    a_tag: assert property (p_tag) else $error("tag check attribute wrong");

    property p_undef;
        instr_valid && instr_ready && !large_system_ext_feature
            |=> undef_exc && $stable(state_reg);
    endproperty
    a_undef: assert property (p_undef) else $error("missing undefined exception");

    property p_sp_addr;
        $rose(mem_req_valid) && instr_reg[9:5] == zero_idx |-> mem_addr == $past(sp_value);
    endproperty
    a_sp_addr: assert property (p_sp_addr) else $error("stack pointer not used");

    property p_operand;
        $rose(mem_req_valid) |-> mem_operand == size_mask(mem_size, $past(rf_src_data));
    endproperty
    a_operand: assert property (p_operand) else $error("operand width wrong");

    property p_cmp_unused;
        mem_req_valid |-> mem_cmp_data == 64'h0;
    endproperty
    a_cmp_unused: assert property (p_cmp_unused) else $error("compare value used");

    property p_max;
        mem_new_valid && !mem_op_min |->
            $signed(size_sext(mem_size, mem_new_data)) >= $signed(size_sext(mem_size, old_reg))
            && $signed(size_sext(mem_size, mem_new_data))
                >= $signed(size_sext(mem_size, mem_operand));
    endproperty
    a_max: assert property (p_max) else $error("max result not largest");

    property p_min;
        mem_new_valid && mem_op_min |->
            $signed(size_sext(mem_size, mem_new_data)) <= $signed(size_sext(mem_size, old_reg))
            && $signed(size_sext(mem_size, mem_new_data))
                <= $signed(size_sext(mem_size, mem_operand));
    endproperty
    a_min: assert property (p_min) else $error("min result not smallest");

    property p_wb_old;
        state_reg == st_wait_old && mem_old_valid && instr_reg[4:0] != zero_idx
            ##1 mem_new_ready [*1]
            |=> wb_valid && wb_data == size_mask(mem_size, $past(mem_old_data, 2));
    endproperty
    a_wb_old: assert property (p_wb_old) else $error("writeback not original value");

    property p_alias;
        mem_new_valid && mem_new_ready && instr_reg[4:0] == zero_idx |=> !wb_valid;
    endproperty
    a_alias: assert property (p_alias) else $error("store-only form wrote back");

    property p_narrow_zext;
        wb_valid && !wb_is64 |-> wb_data[63:32] == 32'h0;
    endproperty
    a_narrow_zext: assert property (p_narrow_zext) else $error("upper bits not zero");

    c_max: cover property (wb_valid && !mem_op_min);
    c_min: cover property (wb_valid && mem_op_min && wb_is64);
    c_alias: cover property (mem_new_valid && mem_new_ready && lat.discard);
    c_undef: cover property (undef_exc);
endmodule : atomic_signed_minmax_exec

// file: tb/amm_mem_model.sv
// Behavioural memory side carrying out the atomic read-modify-write
`timescale 1ns/10ps
module amm_mem_model (
    input wire logic mclk,
    input wire logic mem_req_valid,
    output logic mem_req_ready,
    input wire logic [63:0] mem_addr,
    input wire logic mem_op_min,
    input wire logic [1:0] mem_size,
    input wire logic mem_acquire,
    input wire logic mem_release,
    input wire logic mem_tag_check,
    input wire logic [63:0] mem_operand,
    input wire logic [63:0] mem_cmp_data,
    output logic mem_old_valid,
    output logic [63:0] mem_old_data,
    input wire logic mem_new_valid,
    output logic mem_new_ready,
    input wire logic [63:0] mem_new_data
);
    // Set by the bench; one stall count serves all three phases
    int stall = 0;
    int cnt = 0;
    int phase = 0;
    int done = 0;
    logic [63:0] mem_word = 64'h0;
    logic [63:0] cap_addr, cap_opnd, cap_cmp, cap_new;
    logic [5:0] cap_attr;
    wire go = (phase == 0 && mem_req_valid) || phase == 2 || (phase == 4 && mem_new_valid);

    initial begin
        mem_req_ready = 1'b0;
        mem_old_valid = 1'b0;
        mem_old_data = 64'h0;
        mem_new_ready = 1'b0;
    end

    always @(negedge mclk) begin
        if (phase == 1 || phase == 3 || phase == 5) begin
            mem_req_ready <= 1'b0;
            mem_old_valid <= 1'b0;
            mem_new_ready <= 1'b0;
            // Released data must not keep the last value
            mem_old_data <= ~mem_old_data;
            phase <= (phase + 1) % 6;
            if (phase == 5) begin
                done <= done + 1;
                mem_word <= cap_new;
            end
        end else if (go) begin
            if (cnt < stall) begin
                cnt <= cnt + 1;
            end else begin
                cnt <= 0;
                phase <= phase + 1;
                mem_req_ready <= (phase == 0);
                mem_old_valid <= (phase == 2);
                mem_new_ready <= (phase == 4);
                if (phase == 0) begin
                    cap_addr <= mem_addr;
                    cap_opnd <= mem_operand;
                    cap_cmp <= mem_cmp_data;
                    cap_attr <= {mem_op_min, mem_size, mem_acquire, mem_release, mem_tag_check};
                end
                if (phase == 2) begin
                    mem_old_data <= mem_word;
                end
                if (phase == 4) begin
                    cap_new <= mem_new_data;
                end
            end
        end
    end
endmodule : amm_mem_model

// file: tb/tb_atomic_signed_minmax_exec.sv
// Self-checking bench for the signed min/max atomic executor
`timescale 1ns/10ps
module tb_atomic_signed_minmax_exec;
    import amm_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic large_system_ext_feature = 1'b1;
    logic sp_align_check_en = 1'b0;
    logic instr_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [63:0] sp_value = 64'h0;
    logic [63:0] regs [32];
    logic [63:0] rf_src_data, rf_base_data, mem_addr, mem_operand, mem_cmp_data;
    logic [63:0] mem_old_data, mem_new_data, wb_data;
    logic [4:0] rf_src_idx, rf_base_idx, wb_idx;
    logic [1:0] mem_size;
    logic instr_ready, undef_exc, sp_align_fault, mem_req_valid, mem_req_ready, mem_op_min;
    logic mem_acquire, mem_release, mem_tag_check, mem_old_valid, mem_new_valid;
    logic mem_new_ready, wb_valid, wb_is64;
    logic [69:0] wb_cap;
    int wb_seen, undef_seen, fault_seen, mismatches, total_checks;

    always #25 mclk = ~mclk;
    assign rf_src_data = regs[rf_src_idx];
    assign rf_base_data = regs[rf_base_idx];

    atomic_signed_minmax_exec dut (
        .mclk, .reset, .large_system_ext_feature, .sp_align_check_en, .instr_valid,
        .instr_ready, .instr, .rf_src_idx, .rf_src_data, .rf_base_idx, .rf_base_data,
        .sp_value, .undef_exc, .sp_align_fault, .mem_req_valid, .mem_req_ready, .mem_addr,
        .mem_op_min, .mem_size, .mem_acquire, .mem_release, .mem_tag_check, .mem_operand,
        .mem_cmp_data, .mem_old_valid, .mem_old_data, .mem_new_valid, .mem_new_ready,
        .mem_new_data, .wb_valid, .wb_idx, .wb_is64, .wb_data
    );

    amm_mem_model mem (
        .mclk, .mem_req_valid, .mem_req_ready, .mem_addr, .mem_op_min, .mem_size,
        .mem_acquire, .mem_release, .mem_tag_check, .mem_operand, .mem_cmp_data,
        .mem_old_valid, .mem_old_data, .mem_new_valid, .mem_new_ready, .mem_new_data
    );

    always @(posedge mclk) begin
        if (wb_valid) begin
            wb_seen <= wb_seen + 1;
            wb_cap <= {wb_is64, wb_idx, wb_data};
        end
        undef_seen <= undef_seen + int'(undef_exc);
        fault_seen <= fault_seen + int'(sp_align_fault);
    end

    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] enc(input logic [1:0] sz, input logic mn, input logic a,
            input logic r, input logic [4:0] s, input logic [4:0] b, input logic [4:0] d);
        return {sz, fixed_val, a, r, 1'b1, s, 1'b0, mn ? opc_smin : opc_smax,
            2'h0, b, d};
    endfunction : enc

    task automatic issue(input logic [31:0] w);
        wb_seen = 0;
        undef_seen = 0;
        fault_seen = 0;
        for (int i = 0; i < 20 && instr_ready !== 1'b1; i++) @(negedge mclk);
        instr = w;
        instr_valid = 1'b1;
        @(negedge mclk);
        instr_valid = 1'b0;
    endtask : issue

    task automatic run_op(input logic [1:0] sz, input logic mn, input logic a, input logic r,
            input logic [4:0] s, input logic [4:0] b, input logic [4:0] d,
            input logic [63:0] old, input logic [63:0] val);
        logic [63:0] m;
        logic [63:0] exp_new;
        logic [5:0] exp_attr;
        int sh;
        int n0;
        sh = 64 - (8 << sz);
        m = {64{1'b1}} >> sh;
        // Shift to the top so the narrow sign bit decides the compare
        exp_new = (($signed(old << sh) > $signed(val << sh)) ^ mn) ? old : val;
        exp_attr = {mn, sz, a && d != zero_idx, r, b != zero_idx};
        regs[s] = val;
        if (b != zero_idx) begin
            regs[b] = {59'h40, b};
        end
        mem.mem_word = old;
        n0 = mem.done;
        issue(enc(sz, mn, a, r, s, b, d));
        for (int i = 0; i < 60 && mem.done == n0; i++) @(negedge mclk);
        repeat (3) @(negedge mclk);
        check("access count", mem.done - n0, 1);
        check("address", mem.cap_addr, (b == zero_idx) ? sp_value : regs[b]);
        check("attributes", mem.cap_attr, exp_attr);
        check("operand", mem.cap_opnd, val & m);
        check("compare value", mem.cap_cmp, cmp_unused);
        check("new value", mem.cap_new & m, exp_new & m);
        check("writeback count", wb_seen, d != zero_idx);
        if (d != zero_idx) begin
            check("writeback", wb_cap, {sz == size_dword, d, old & m});
        end
    endtask : run_op

    task automatic refused(input logic [31:0] w, input int eu, input int ef);
        int n0;
        n0 = mem.done;
        issue(w);
        repeat (6) @(negedge mclk);
        check("undefined", undef_seen, eu);
        check("sp fault", fault_seen, ef);
        check("no access", mem.done - n0, 0);
    endtask : refused

    task automatic t_narrow;
        mem.stall = 2;
        run_op(size_byte, 1'b0, 1'b1, 1'b0, 5'h1, 5'h2, 5'h3, 64'h5a5a_5a5a_5a5a_5a80,
            64'hffff_ffff_ffff_ff05);
        run_op(size_half, 1'b0, 1'b1, 1'b1, 5'h4, 5'h5, 5'h6, 64'h1234_5678_9abc_7fff,
            64'h8000);
        mem.stall = 0;
        $display("test narrow done");
    endtask : t_narrow

    task automatic t_wide;
        for (int z = 2; z < 4; z++) begin
            for (int ar = 0; ar < 4; ar++) begin
                run_op(2'(z), 1'b1, ar[1], ar[0], 5'h7, 5'h8, 5'h9, 64'h0000_0003_ffff_fffe,
                    64'h5);
            end
        end
        run_op(size_dword, 1'b0, 1'b0, 1'b0, 5'h7, 5'h8, 5'h9, 64'h8000_0000_0000_0000,
            64'hffff_ffff_ffff_ffff);
        $display("test wide done");
    endtask : t_wide

    task automatic t_alias;
        run_op(size_word, 1'b0, 1'b0, 1'b1, 5'ha, 5'hb, zero_idx, 64'h10, 64'h20);
        run_op(size_half, 1'b1, 1'b1, 1'b0, 5'ha, 5'hb, zero_idx, 64'h10, 64'h20);
        $display("test alias done");
    endtask : t_alias

    task automatic t_stack;
        sp_align_check_en = 1'b1;
        sp_value = 64'h7ff0;
        run_op(size_dword, 1'b1, 1'b0, 1'b0, 5'hc, zero_idx, 5'hd, 64'h3, 64'h9);
        sp_value = 64'h7ff8;
        refused(enc(size_word, 1'b0, 1'b0, 1'b0, 5'hc, zero_idx, 5'hd), 0, 1);
        // Misaligned stack is only a fault while checking is enabled
        sp_align_check_en = 1'b0;
        run_op(size_word, 1'b0, 1'b0, 1'b0, 5'hc, zero_idx, 5'hd, 64'h3, 64'h9);
        $display("test stack done");
    endtask : t_stack

    task automatic t_undef;
        large_system_ext_feature = 1'b0;
        for (int z = 0; z < 4; z++) begin
            refused(enc(2'(z), z[0], 1'b1, 1'b1, 5'h1, 5'h2, 5'h3), 1, 0);
        end
        large_system_ext_feature = 1'b1;
        // Unknown operation code is refused even with the feature present
        refused(enc(size_word, 1'b0, 1'b0, 1'b0, 5'h1, 5'h2, 5'h3) | 32'h2000, 1, 0);
        $display("test undef done");
    endtask : t_undef

    task automatic t_reset;
        int n0;
        n0 = mem.done;
        regs[5'h1] = 64'h1;
        regs[5'h2] = 64'h40;
        issue(enc(size_word, 1'b0, 1'b0, 1'b0, 5'h1, 5'h2, 5'h3));
        // Reset lands in the register read cycle, before any request
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        check("reset handshakes", {instr_ready, mem_req_valid, mem_new_valid, wb_valid,
            undef_exc, sp_align_fault}, 6'b100000);
        check("reset data", mem_addr | wb_data | mem_new_data, 64'h0);
        check("reset no access", mem.done - n0, 0);
        run_op(size_word, 1'b1, 1'b0, 1'b0, 5'h1, 5'h2, 5'h3, 64'h7, 64'h4);
        $display("test reset done");
    endtask : t_reset

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        t_narrow();
        t_wide();
        t_alias();
        t_stack();
        t_undef();
        t_reset();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #(3000 * 50);
        mismatches++;
        end_of_test();
    end
endmodule : tb_atomic_signed_minmax_exec
